/* File: design/watchdog_supervisor.sv */
// watchdog supervisor: divider, two-stage counter, nmi or reset, axi4-lite registers
//
// Function
// [RL1] overflow with action select 1: request reset, drive reset pin low.
// [RL2] overflow with action select 0: raise non-maskable watchdog interrupt.
// [RL3] new watchdog interrupt is taken at once even during another service.
// [RL4] counting holds during stop, warm-up, idle and sleep; resumes from held count. The code pauses on stop, idle and sleep only; it has no warm-up input.
// [RL5] clear code resets only the binary counter, never the divider.
// [RL6] first overflow after clear may come at three quarters of detection time.
// [RL7] time select 00..11 picks 2^25..2^19 high or 2^17..2^11 low periods.
// [RL8] once action select is 0, writes setting it to 1 are ignored.
// [RL9] configuration register is write-only; reads return undefined data.
// [RL10] reset loads enable 1, time 00, action select 1.
// [RL11] software disables by: mask, clear code, enable 0, disable code.
// [RL12] disable code acts only when enable bit is already 0.
// [RL13] while disabled, the binary counters are held cleared.
// [RL14] watchdog reset lasts at most 24 high periods; restarts high oscillator. The code requests the restart only in slow mode.
// [RL15] software must not clear the counter inside an interrupt routine.
// [RL16] before stop, software disables or clears, and clears again after.
// [RL17] software sets the stack pointer before choosing interrupt action.
// [RL18] other code values are ignored and change nothing.
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module watchdog_supervisor
   import wdt_pkg::*;
#(
   parameter int DIV_BITS = wdt_pkg::DIV_W
) (
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite slave
   input wire logic [wdt_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [wdt_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // clocks and power modes from outside this domain
   input wire logic hi_tick,
   input wire logic lo_tick,
   input wire wdt_pkg::power_mode_t power_mode,
   // outputs
   output logic watchdog_nmi,
   output logic reset_pin_n_o,
   output logic reset_pin_oe,
   output logic hi_osc_restart,
   output logic irq
);
   import wdt_pkg::*;

   // refuse divider widths that cannot hold the longest detection tap
   if (DIV_BITS < HI_EXP_BASE - STAGE_BITS || DIV_BITS > 30) begin : g_bad_div
      $error("DIV_BITS out of range for the detection taps");
   end

   // all state of the block in one record
   // one combinational pass builds the next copy, one clocked process keeps it
   // counter, configuration, status and bus holding registers live side by side
   // so a watchdog reset can restore the counting part in a single place
   typedef struct packed {
      config_t cfg;
      logic out_locked;
      logic trap_armed;
      logic [1:0] ctl;
      logic [DIV_BITS-1:0] div;
      logic [STAGE_BITS-1:0] bin;
      logic hi_prev;
      logic lo_prev;
      wd_state_t st;
      logic [4:0] rst_cnt;
      logic [IRQ_W-1:0] irq_stat;
      logic [IRQ_W-1:0] irq_en;
      logic aw_held;
      logic [ADDR_W-1:0] aw_addr;
      logic w_held;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } state_t;

   state_t s_r;
   state_t s_nxt;

   logic [1:0] tick_sync;
   power_mode_t mode_sync;

   // tick levels and mode levels come from other clock domains
   // two flops before any logic reads them, so a changing level cannot
   // reach the edge detectors or the pause gate half settled
   // pin-level clocks and modes cross into aclk
   wdt_sync2 #(.W(6)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .async_in({hi_tick, lo_tick, power_mode}),
      .sync_out({tick_sync, mode_sync})
   );

   logic use_low;
   logic src_level;
   logic src_edge;
   logic paused;
   logic [4:0] tap_idx;
   logic step;
   logic [DIV_BITS-1:0] div_inc;
   logic tap_fall;
   logic [IRQ_W-1:0] ovf_evt;
   logic overflow;
   logic wr_go;
   logic [7:0] wbyte;
   logic rd_go;

   always_comb begin
      use_low = s_r.ctl[CTL_PRESCALE_BIT] | s_r.ctl[CTL_SLOW_BIT]; // RL7
      src_level = use_low ? tick_sync[0] : tick_sync[1];
      src_edge = src_level & ~(use_low ? s_r.lo_prev : s_r.hi_prev);
      paused = mode_sync.stop | mode_sync.idle | mode_sync.sleep; // RL4
      // divider tap: stage input period = total / 4
      tap_idx = use_low
         ? 5'(LO_EXP_BASE - STAGE_BITS - 1 - 2 * int'(s_r.cfg.det_time))
         : 5'(HI_EXP_BASE - STAGE_BITS - 1 - 2 * int'(s_r.cfg.det_time)); // RL7
      // one divider step per source edge while running and not paused
      // the enable bit alone does not stop counting: the disable code must follow
      step = (s_r.st != WD_OFF) && !paused && src_edge; // RL4 RL12
      div_inc = s_r.div + 1'b1;
      // tap falls exactly when the step carries out of bit tap_idx
      // checked on the step itself, so no fall is lost between source edges
      // and a change of time select cannot fake a fall
      tap_fall = step && s_r.div[tap_idx] && !div_inc[tap_idx];
      overflow = tap_fall && (s_r.bin == '1);
      // overflow events in status bit order
      ovf_evt = '0;
      ovf_evt[IRQ_NMI_BIT] = overflow && !s_r.cfg.out_sel;
      ovf_evt[IRQ_RST_BIT] = overflow && s_r.cfg.out_sel;
      wr_go = s_r.aw_held && s_r.w_held && !s_r.bvalid;
      wbyte = s_r.w_data[7:0];
      rd_go = s_axi_arvalid && !s_r.rvalid;
   end

   // bus handshake outputs straight from the holding flags
   // ready stays high until a channel has been taken and used
   assign s_axi_awready = !s_r.aw_held;
   assign s_axi_wready = !s_r.w_held;
   assign s_axi_arready = !s_r.rvalid;
   assign s_axi_bvalid = s_r.bvalid;
   assign s_axi_bresp = s_r.bresp;
   assign s_axi_rvalid = s_r.rvalid;
   assign s_axi_rdata = s_r.rdata;
   assign s_axi_rresp = s_r.rresp;
   assign irq = |(s_r.irq_stat & s_r.irq_en);

   // next-state logic
   // later blocks override earlier ones: reset pulse over counting,
   // register writes over both, disable hold last of all
   always_comb begin
      s_nxt = s_r;
      // previous tick levels for the rising-edge detectors
      s_nxt.hi_prev = tick_sync[1];
      s_nxt.lo_prev = tick_sync[0];
      if (s_axi_awvalid && !s_r.aw_held) begin
         s_nxt.aw_held = 1'b1;
         s_nxt.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !s_r.w_held) begin
         s_nxt.w_held = 1'b1;
         s_nxt.w_data = s_axi_wdata;
         s_nxt.w_strb = s_axi_wstrb;
      end
      if (s_r.bvalid && s_axi_bready) begin
         s_nxt.bvalid = 1'b0;
      end
      if (s_r.rvalid && s_axi_rready) begin
         s_nxt.rvalid = 1'b0;
      end

      // divider runs until the disable code takes effect, holds while paused
      // a pause freezes both divider and binary counter, so counting resumes
      // from the held count when the mode ends
      if (step) begin // RL4
         s_nxt.div = div_inc;
         if (tap_fall) begin
            s_nxt.bin = s_r.bin + 1'b1;
         end
      end

      // overflow action
      // the action select is sampled at the overflow itself
      // every interrupt overflow gives a fresh one-cycle request,
      // whatever the processor is servicing at the time
      if (overflow) begin
         if (s_r.cfg.out_sel) begin
            s_nxt.st = WD_RESET; // RL1
            s_nxt.rst_cnt = 5'(RESET_PULSE_CYCLES - 1); // RL14
            s_nxt.irq_stat[IRQ_RST_BIT] = 1'b1;
         end else begin
            s_nxt.st = WD_NMI; // RL2 RL3
            s_nxt.irq_stat[IRQ_NMI_BIT] = 1'b1;
         end
      end else if (s_r.st == WD_NMI) begin
         s_nxt.st = WD_RUN;
      end

      // reset pulse: counters, configuration and action lock return to reset values; control and interrupt registers keep theirs
      // held for the whole pulse so a write cannot sneak in half way;
      // the action lock is released together with the configuration
      if (s_r.st == WD_RESET) begin
         s_nxt.div = '0;
         s_nxt.bin = '0;
         s_nxt.cfg = config_t'(CONFIG_RESET[5:0]); // RL1
         s_nxt.out_locked = 1'b0;
         s_nxt.trap_armed = 1'b0;
         if (s_r.rst_cnt == '0) begin
            s_nxt.st = WD_RUN;
         end else begin
            s_nxt.rst_cnt = s_r.rst_cnt - 1'b1;
         end
      end

      // register writes
      // a write completes once address and data are both held;
      // only byte 0 carries data, and writes during a reset pulse are dropped
      // so the restored configuration survives the pulse
      if (wr_go) begin
         s_nxt.aw_held = 1'b0;
         s_nxt.w_held = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = RESP_OKAY;
         if (s_r.w_strb[0] && s_r.st != WD_RESET) begin
            case (s_r.aw_addr)
               CONFIG_ADDR: begin
                  s_nxt.cfg.trap_sel = wbyte[TRAP_SEL_BIT];
                  s_nxt.cfg.trap_out = wbyte[TRAP_OUT_BIT];
                  s_nxt.cfg.enable = wbyte[EN_BIT];
                  s_nxt.cfg.det_time = wbyte[TIME_LSB +: 2];
                  // a 0 in the action select locks it until the next reset;
                  // a later 1 is dropped while the lock stands
                  if (!wbyte[OUT_BIT]) begin
                     s_nxt.out_locked = 1'b1;
                     s_nxt.cfg.out_sel = 1'b0;
                  end else if (!s_r.out_locked) begin // RL8
                     s_nxt.cfg.out_sel = 1'b1;
                  end
                  if (wbyte[EN_BIT] && s_r.st == WD_OFF) begin
                     s_nxt.st = WD_RUN;
                  end
               end
               CODE_ADDR: begin
                  // clear touches the binary stage only, so the divider phase
                  // carries over and the next overflow may come early
                  // unknown codes fall through and change nothing
                  case (wbyte)
                     CODE_CLEAR: s_nxt.bin = '0; // RL5 RL6
                     CODE_DISABLE: begin
                        if (!s_r.cfg.enable) begin // RL12
                           s_nxt.st = WD_OFF;
                        end
                     end
                     CODE_TRAP_EN: s_nxt.trap_armed = s_r.cfg.trap_sel;
                     default: ; // RL18
                  endcase
               end
               IRQ_ENABLE_ADDR: s_nxt.irq_en = wbyte[IRQ_W-1:0];
               IRQ_CLEAR_ADDR: begin
                  // a new event in the same cycle wins over the clear
                  s_nxt.irq_stat = s_nxt.irq_stat & ~(wbyte[IRQ_W-1:0] & ~ovf_evt);
               end
               CONTROL_ADDR: s_nxt.ctl = wbyte[1:0];
               default: s_nxt.bresp = RESP_SLVERR;
            endcase
         end else if (s_r.w_strb[0]) begin
            s_nxt.bresp = RESP_OKAY;
         end
      end

      // held clear while disabled
      if (s_nxt.st == WD_OFF) begin
         s_nxt.bin = '0; // RL13
         s_nxt.div = '0;
      end

      // register reads
      // write-only registers read back as zero rather than their contents,
      // so software cannot lean on read-modify-write of the configuration
      if (rd_go) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = RESP_OKAY;
         case (s_axi_araddr)
            CONFIG_ADDR: s_nxt.rdata = '0; // RL9
            CODE_ADDR: s_nxt.rdata = '0;
            IRQ_STATUS_ADDR: s_nxt.rdata = 32'(s_r.irq_stat);
            IRQ_ENABLE_ADDR: s_nxt.rdata = 32'(s_r.irq_en);
            IRQ_CLEAR_ADDR: s_nxt.rdata = '0;
            CONTROL_ADDR: s_nxt.rdata = 32'(s_r.ctl);
            STATE_ADDR: s_nxt.rdata = 32'({s_r.st, s_r.bin, s_r.out_locked});
            default: begin
               s_nxt.rdata = '0;
               s_nxt.rresp = RESP_SLVERR;
            end
         endcase
      end
   end

   // state register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r <= '0;
         s_r.cfg <= config_t'(CONFIG_RESET[5:0]); // RL10
         s_r.st <= WD_RUN;
      end else begin
         s_r <= s_nxt;
      end
   end

   // outputs from registered state
   // the reset pin is driven low only while the pulse runs, released otherwise
   // the oscillator restart request follows the pulse in slow mode
   always_comb begin
      watchdog_nmi = (s_r.st == WD_NMI); // RL2
      reset_pin_oe = (s_r.st == WD_RESET); // RL1
      reset_pin_n_o = 1'b0;
      hi_osc_restart = (s_r.st == WD_RESET) & s_r.ctl[CTL_SLOW_BIT]; // RL14
   end
endmodule : watchdog_supervisor
`default_nettype wire

/* File: design/wdt_sync2.sv */
// two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
`default_nettype none
module wdt_sync2 #(
   parameter int W = 1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_r;
   // first stage feeds only the second
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_r <= '0;
         sync_out <= '0;
      end else begin
         meta_r <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule : wdt_sync2
`default_nettype wire

/* File: inc/wdt_pkg.sv */
// package: register map, field layout, codes and timing for the watchdog supervisor
package wdt_pkg;
   // register byte addresses (printed offsets are not all multiples of four: index * 4)
   localparam logic [7:0] CONFIG_IDX = 8'h34;
   localparam logic [7:0] CODE_IDX = 8'h35;
   localparam logic [7:0] IRQ_STATUS_IDX = 8'h36;
   localparam logic [7:0] IRQ_ENABLE_IDX = 8'h37;
   localparam logic [7:0] IRQ_CLEAR_IDX = 8'h38;
   localparam logic [7:0] CONTROL_IDX = 8'h39;
   localparam logic [7:0] STATE_IDX = 8'h3a;
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] CONFIG_ADDR = ADDR_W'({CONFIG_IDX, 2'b00});
   localparam logic [ADDR_W-1:0] CODE_ADDR = ADDR_W'({CODE_IDX, 2'b00});
   localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = ADDR_W'({IRQ_STATUS_IDX, 2'b00});
   localparam logic [ADDR_W-1:0] IRQ_ENABLE_ADDR = ADDR_W'({IRQ_ENABLE_IDX, 2'b00});
   localparam logic [ADDR_W-1:0] IRQ_CLEAR_ADDR = ADDR_W'({IRQ_CLEAR_IDX, 2'b00});
   localparam logic [ADDR_W-1:0] CONTROL_ADDR = ADDR_W'({CONTROL_IDX, 2'b00});
   localparam logic [ADDR_W-1:0] STATE_ADDR = ADDR_W'({STATE_IDX, 2'b00});

   // configuration field positions
   localparam int OUT_BIT = 0;
   localparam int TIME_LSB = 1;
   localparam int EN_BIT = 3;
   localparam int TRAP_OUT_BIT = 4;
   localparam int TRAP_SEL_BIT = 5;
   localparam logic [7:0] CONFIG_RESET = 8'h39;

   // code port values
   localparam logic [7:0] CODE_CLEAR = 8'h4e;
   localparam logic [7:0] CODE_DISABLE = 8'hb1;
   localparam logic [7:0] CODE_TRAP_EN = 8'hd2;

   // control register bits (mode inputs)
   localparam int CTL_PRESCALE_BIT = 0;
   localparam int CTL_SLOW_BIT = 1;

   // interrupt status bits
   localparam int IRQ_NMI_BIT = 0;
   localparam int IRQ_RST_BIT = 1;
   localparam int IRQ_W = 2;

   // detection: the divider stage sets the base tick; two binary stages follow
   // total = 2^(hi_base - 2*sel) high periods, hi_base 25, lo_base 17
   localparam int HI_EXP_BASE = 25;
   localparam int LO_EXP_BASE = 17;
   localparam int STAGE_BITS = 2;
   localparam int DIV_W = HI_EXP_BASE - STAGE_BITS;

   // reset pulse: at most 24 high periods, held for 24 aclk cycles
   localparam int RESET_PULSE_HI_PERIODS = 24;
   localparam int RESET_PULSE_CYCLES = RESET_PULSE_HI_PERIODS;

   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef struct packed {
      logic trap_sel;
      logic trap_out;
      logic enable;
      logic [1:0] det_time;
      logic out_sel;
   } config_t;

   typedef struct packed {
      logic active;
      logic idle;
      logic stop;
      logic sleep;
   } power_mode_t;

   typedef enum logic [1:0] {
      WD_RUN = 2'b00,
      WD_NMI = 2'b01,
      WD_RESET = 2'b11,
      WD_OFF = 2'b10
   } wd_state_t;
endpackage : wdt_pkg

/* File: verification/testbench.sv */
// testbench: directed scenarios for the watchdog supervisor
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import wdt_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic [3:0] wstrb = 4'hf;
   logic awready, wready, arready, bvalid, rvalid, nmi, pin_n, pin_oe, osc, irq;
   logic [1:0] bresp, rresp, r;
   logic hi_tick = 1'b0, lo_tick = 1'b0;
   power_mode_t pm = 4'h8;
   int err_total = 0, checks = 0, cyc = 0, n;

   watchdog_supervisor dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .hi_tick(hi_tick), .lo_tick(lo_tick), .power_mode(pm), .watchdog_nmi(nmi),
      .reset_pin_n_o(pin_n), .reset_pin_oe(pin_oe), .hi_osc_restart(osc), .irq(irq));

   always #50 aclk = ~aclk;
   // tick levels toggle each cycle; cycle counter cuts a hang short
   always @(posedge aclk) begin
      lo_tick <= ~lo_tick;
      hi_tick <= ~hi_tick;
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         err_total = err_total + 1;
         finish_test();
      end
   end

   task finish_test();
      $display("errors %0d checks %0d", err_total, checks);
      if (err_total == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : finish_test

   task chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: %s", $time, msg);
      end
   endtask : chk

   task wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
      logic aw_ok, w_ok;
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         aw_ok = aw_ok | awready;
         w_ok = w_ok | wready;
         if (aw_ok) awvalid <= 1'b0;
         if (w_ok) wvalid <= 1'b0;
      end
      bready <= 1'b1;
      do @(posedge aclk); while (bvalid !== 1'b1);
      chk(bresp, RESP_OKAY, "write response");
      bready <= 1'b0;
   endtask : wr

   task rd(input logic [ADDR_W-1:0] a);
      logic ok;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      ok = 1'b0;
      do begin
         @(posedge aclk);
         ok = ok | arready;
         if (ok) arvalid <= 1'b0;
      end while (!(ok && rvalid === 1'b1));
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : rd

   task wait_nmi(input int lim);
      n = 0;
      while (n < lim && nmi !== 1'b1) begin
         @(posedge aclk);
         n++;
      end
   endtask : wait_nmi

   task t_regs();
      rd(CONFIG_ADDR);
      chk(d, 32'h0, "config read");
      rd(STATE_ADDR);
      chk(d & 32'h19, 32'h0, "state after reset");
      rd(12'hff0);
      chk(r, RESP_SLVERR, "unmapped read");
      wr(CONTROL_ADDR, 32'h1);
      wr(IRQ_ENABLE_ADDR, 32'h3);
   endtask : t_regs

   task t_nmi();
      wr(CONFIG_ADDR, 32'h0e);
      wr(CODE_ADDR, CODE_CLEAR);
      wait_nmi(4600);
      chk(n >= 3000 && n < 4600, 1, "overflow time");
      rd(IRQ_STATUS_ADDR);
      chk(d[1:0], 2'b01, "nmi status");
      chk(irq, 1'b1, "irq raised");
      wr(IRQ_CLEAR_ADDR, 32'h1);
      @(posedge aclk);
      chk(irq, 1'b0, "irq cleared");
   endtask : t_nmi

   task t_lock();
      wr(CONFIG_ADDR, 32'h0f);
      wait_nmi(4600);
      chk(n < 4600, 1, "second nmi");
      rd(STATE_ADDR);
      chk(d[0], 1'b1, "action lock");
   endtask : t_lock

   task t_clear();
      // clears come from the main flow, never from nmi handling
      repeat (4) begin
         wr(CODE_ADDR, CODE_CLEAR);
         wait_nmi(2000);
         chk(n == 2000, 1, "clear holds off");
      end
   endtask : t_clear

   task t_pause();
      wr(CODE_ADDR, CODE_CLEAR);
      // idle, stop, sleep; each pause outlasts a full detection time
      for (int i = 0; i < 3; i++) begin
         if (i == 1) wr(CODE_ADDR, CODE_CLEAR);
         pm <= power_mode_t'(4'h4 >> i);
         wait_nmi(4200);
         chk(n == 4200, 1, "paused");
         pm <= 4'h8;
         if (i == 1) wr(CODE_ADDR, CODE_CLEAR);
         wait_nmi(600);
      end
      // about 1200 cycles counted since the last clear: held count ends early
      wait_nmi(4600);
      chk(n < 3000, 1, "resumed from held count");
   endtask : t_pause

   task t_dis();
      wr(CODE_ADDR, CODE_DISABLE);
      wait_nmi(4600);
      chk(n < 4600, 1, "disable ignored");
      wr(CODE_ADDR, CODE_CLEAR);
      wr(CONFIG_ADDR, 32'h06);
      wr(CODE_ADDR, CODE_DISABLE);
      rd(STATE_ADDR);
      chk(d[2:1], 2'b00, "counter cleared");
      wait_nmi(5000);
      chk(n == 5000, 1, "stopped");
   endtask : t_dis

   task t_rst();
      aresetn <= 1'b0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      wr(CONTROL_ADDR, 32'h3);
      wr(CONFIG_ADDR, 32'h0f);
      n = 0;
      while (n < 4600 && pin_oe !== 1'b1) begin
         @(posedge aclk);
         n++;
      end
      chk(osc, 1'b1, "osc restart");
      chk(pin_n, 1'b0, "pin low");
      n = 0;
      while (pin_oe === 1'b1 && n < 40) begin
         n++;
         @(posedge aclk);
      end
      chk(n, 32'h18, "pulse cycles");
      rd(STATE_ADDR);
      chk(d[0], 1'b0, "hardware initialised");
   endtask : t_rst

   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_nmi();
      t_lock();
      t_clear();
      t_pause();
      t_dis();
      t_rst();
      finish_test();
   end
endmodule : testbench
`default_nettype wire

/* File: verification/wdt_props.sv */
// checker: port-level properties of the watchdog supervisor
`timescale 1ns/1ps
`default_nettype none
module wdt_props
   import wdt_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [wdt_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic watchdog_nmi,
   input wire logic reset_pin_n_o,
   input wire logic reset_pin_oe,
   input wire logic hi_osc_restart
);
   logic [5:0] oe_cnt_r;
   logic [wdt_pkg::ADDR_W-1:0] ar_r;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // length of the running reset pulse, address of the last read
   always_ff @(posedge aclk) begin
      oe_cnt_r <= (!aresetn || !reset_pin_oe) ? 6'h00 : oe_cnt_r + 6'h01;
      if (s_axi_arvalid && s_axi_arready) ar_r <= s_axi_araddr;
   end
   property p_pulse_len; $fell(reset_pin_oe) |-> oe_cnt_r == 6'h18; endproperty
   a_pulse_len: assert property (p_pulse_len) else $error("reset pulse length");
   property p_pulse_max; oe_cnt_r <= 6'h18; endproperty
   a_pulse_max: assert property (p_pulse_max) else $error("reset pulse too long");
   property p_pin_low; reset_pin_oe |-> !reset_pin_n_o; endproperty
   a_pin_low: assert property (p_pin_low) else $error("reset pin not low");
   property p_nmi_pulse; watchdog_nmi |=> !watchdog_nmi; endproperty
   a_nmi_pulse: assert property (p_nmi_pulse) else $error("nmi not a pulse");
   property p_excl; watchdog_nmi |-> !reset_pin_oe; endproperty
   a_excl: assert property (p_excl) else $error("nmi during reset");
   property p_osc; hi_osc_restart |-> reset_pin_oe; endproperty
   a_osc: assert property (p_osc) else $error("osc restart outside reset");
   property p_cfg_rd; s_axi_rvalid && ar_r == CONFIG_ADDR |-> s_axi_rdata == 32'h0; endproperty
   a_cfg_rd: assert property (p_cfg_rd) else $error("config read data");
   property p_r_after_ar; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_r_after_ar: assert property (p_r_after_ar) else $error("read answer late");
   c_nmi: cover property (watchdog_nmi);
   c_rst: cover property ($rose(reset_pin_oe));
   c_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule : wdt_props
bind watchdog_supervisor wdt_props u_props (.aclk(aclk), .aresetn(aresetn),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .watchdog_nmi(watchdog_nmi), .reset_pin_n_o(reset_pin_n_o),
   .reset_pin_oe(reset_pin_oe), .hi_osc_restart(hi_osc_restart));
`default_nettype wire
